// [rtl/channel_regs_pkg.sv]
package channel_regs_pkg;
  // Register offsets on the command port
  localparam logic [6:0] ADDR_SRC_SHIFT = 7'h08;
  localparam logic [6:0] ADDR_THR = 7'h09;
  localparam logic [6:0] ADDR_DEBOUNCE = 7'h0a;
  localparam logic [6:0] ADDR_MON_LO = 7'h0b;
  localparam logic [6:0] ADDR_MON_HI = 7'h0c;
  localparam logic [6:0] ADDR_RT = 7'h0d;
  localparam logic [6:0] ADDR_RBK = 7'h0e;
  localparam logic [6:0] ADDR_ET = 7'h0f;
  localparam logic [6:0] ADDR_EBRK = 7'h10;
  localparam logic [6:0] ADDR_MASK = 7'h11;
  // Command byte layout
  localparam int CMD_WRITE_BIT = 7;
  // Field positions
  localparam int SCALE_LSB = 4;
  localparam int OVER_BIT = 7;
  localparam int GAIN_BIT = 6;
  localparam int RECT_BIT = 5;
  localparam int HOOK_DB_LSB = 4;
  // Mask and event bit positions
  localparam int MB_GK = 4;
  localparam int MB_HK = 3;
  localparam int MB_OT = 2;
  localparam int MB_RAMP = 1;
  localparam int MB_POL = 0;
  // Reset values
  localparam logic [7:0] RT_RST = 8'h13;
  localparam logic [7:0] RBK_RST = 8'h19;
  localparam logic [7:0] ET_RST = 8'h40;
  localparam logic [7:0] EBRK_RST = 8'h64;
  localparam logic [4:0] MASK_RST = 5'h1f;
  // Meter scaling
  localparam logic [3:0] SHIFT_MAX_CODE = 4'ha;
  localparam logic [3:0] SHIFT_CAP = 4'hb;
  localparam int GAIN_SHIFT = 4;
  localparam int THR_SHIFT = 12;
  // Timing, clock at 20 MHz
  localparam int CLK_PERIOD_NS = 50;
  localparam int HOOK_TICK_NS = 125000;
  localparam int HOOK_TICK_CYCLES = (HOOK_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_TICK_NS = 500000;
  localparam int PIN_TICK_CYCLES_DEF = (PIN_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HOOK_INTERVALS = 8'h10;
  localparam logic [7:0] PIN_BASE_TICKS = 8'h05;
  localparam logic [7:0] PIN_STEP_TICKS = 8'h04;
  // Tone detector time units as log2 of ms
  localparam int RT_UNIT_SHIFT = 4;
  localparam int BRK_UNIT_SHIFT = 2;
  // Meter source codes
  typedef enum logic [3:0] {
    SRC_TIP_DC = 4'h0,
    SRC_DC_DIFF = 4'h4,
    SRC_LINE = 4'h9,
    SRC_PIN3 = 4'ha,
    SRC_PIN4 = 4'hb,
    SRC_RING_TRIP = 4'hc,
    SRC_HALF_SUPPLY = 4'hd,
    SRC_ENC_OFFSET = 4'he,
    SRC_PIN_DIFF = 4'hf
  } meter_source_type;
  // Command port states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DATA = 2'b10
  } bus_state_type;
endpackage : channel_regs_pkg

// [rtl/debounce_filter.sv]
module debounce_filter
  import channel_regs_pkg::*;
(
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic tick_in,
  input wire logic [7:0] need_in,
  input wire logic raw_in,
  output logic level_out
);
  // Stable-interval counter and accepted level
  typedef struct packed {
    logic [7:0] cnt;
    logic level;
  } db_state_type;
  db_state_type s_r;
  db_state_type s_nxt;

  // Count intervals of steady disagreement
  always_comb begin
    s_nxt = s_r;
    if (raw_in == s_r.level) begin
      // Any bounce back restarts the wait
      s_nxt.cnt = 8'h00;
    end else if (tick_in) begin
      // First interval may be partial, so one extra tick keeps the minimum
      if (s_r.cnt >= need_in) begin
        s_nxt.level = raw_in;
        s_nxt.cnt = 8'h00;
      end else begin
        s_nxt.cnt = 8'(s_r.cnt + 8'h01);
      end
    end
  end

  // State register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_out = s_r.level;

  property p_level_on_tick;
    @(posedge clock_in) disable iff (!rstn_in)
    $changed(level_out) |-> $past(tick_in) && $past(raw_in) == level_out;
  endproperty
  a_level_on_tick: assert property (p_level_on_tick)
    else $error("debounced level moved off an interval tick");
endmodule : debounce_filter

// [rtl/channel_meter_tone_mask_regs.sv]
// Summary of operation
// - Shift code scales meter, capped at 1/2048
// - Four-bit code selects DC meter source
// - Gain bit multiplies meter result by 16
// - Rectifier bit enables meter rectification
// - Flag set when |result| exceeds code/8 scale
// - Over-threshold flag read-only, resets to zero
// - Hook debounce: sixteen intervals of (code+1)*0.125ms
// - Pin debounce 2.5ms plus 2ms per step
// - Low monitor holds low or compressed byte
// - High monitor holds high byte, else 00
// - Monitors read-only, only in port mode
// - Recognition time is value times 16 ms
// - Recognition break is value times 4 ms
// - End detection is value times 4 ms
// - End break is value in milliseconds
// - Unmasked ground-key changes raise events
// - Unmasked off-hook changes raise events
// - Unmasked overheat rising edge raises event
// - Unmasked ramp-done rising edge raises event
// - Unmasked key polarity change raises event
// - All five masks set after reset
// - Command top bit: one write, zero read
module channel_meter_tone_mask_regs
  import channel_regs_pkg::*;
#(
  parameter int PIN_TICK_CYCLES = PIN_TICK_CYCLES_DEF
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  output logic [7:0] read_data_out,
  output logic read_valid_out,
  input wire logic mpi_mode_in,
  input wire logic signed [15:0] meter_raw_in,
  input wire logic meter_valid_in,
  output logic signed [19:0] meter_result_out,
  output logic over_threshold_flag_out,
  output logic [3:0] meter_source_select_out,
  output logic meter_source_valid_out,
  input wire logic [15:0] tx_sample_in,
  input wire logic tx_sample_valid_in,
  input wire logic linear_coding_in,
  input wire logic hook_raw_in,
  input wire logic ground_key_raw_in,
  output logic hook_level_out,
  output logic ground_key_level_out,
  input wire logic [3:0] pin_raw_in,
  input wire logic [3:0] pin_is_input_in,
  output logic [3:0] pin_level_out,
  output logic [11:0] recognition_time_ms_out,
  output logic [9:0] recognition_break_ms_out,
  output logic [9:0] end_detect_ms_out,
  output logic [7:0] end_detect_break_ms_out,
  input wire logic [3:0] ground_key_status_in,
  input wire logic [3:0] off_hook_status_in,
  input wire logic overheat_status_in,
  input wire logic ramp_done_in,
  input wire logic key_polarity_status_in,
  output logic [4:0] event_out
);
  // Whole block state
  typedef struct packed {
    bus_state_type st;
    logic [6:0] addr;
    logic [3:0] scale;
    logic [3:0] src;
    logic gain;
    logic rect;
    logic [2:0] thr;
    logic over;
    logic [3:0] hook_db;
    logic [3:0] pin_db;
    logic [7:0] mon_lo;
    logic [7:0] mon_hi;
    logic [7:0] rt;
    logic [7:0] rbk;
    logic [7:0] et;
    logic [7:0] ebrk;
    logic [4:0] mask;
    logic [7:0] rdata;
    logic rvalid;
    logic [19:0] meter;
    logic [3:0] gk_prev;
    logic [3:0] hk_prev;
    logic ot_prev;
    logic ramp_prev;
    logic pol_prev;
    logic [4:0] ev;
    logic [11:0] hdiv;
    logic [3:0] hint;
    logic htick;
    logic [15:0] pdiv;
    logic ptick;
  } state_type;
  state_type s_r;
  state_type s_nxt;

  // Meter datapath helpers
  logic signed [19:0] m_gain;
  logic signed [19:0] m_shift;
  logic signed [19:0] m_out;
  logic [19:0] m_abs;
  logic [19:0] thr_level;
  logic [3:0] shamt;
  logic [7:0] rd_mux;
  logic [7:0] pin_need;
  logic [3:0] pin_db_level;

  // Next-state logic
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    s_nxt.htick = 1'b0;
    s_nxt.ptick = 1'b0;
    // Meter scaling chain
    m_gain = s_r.gain ? (20'(meter_raw_in) <<< GAIN_SHIFT) : 20'(meter_raw_in);
    shamt = (s_r.scale > SHIFT_MAX_CODE) ? SHIFT_CAP : s_r.scale;
    m_shift = m_gain >>> shamt;
    m_out = (s_r.rect && m_shift[19]) ? 20'(-m_shift) : m_shift;
    m_abs = m_out[19] ? 20'(-m_out) : m_out;
    thr_level = 20'(s_r.thr) << THR_SHIFT;
    // Read mux, unused bits zero
    case (byte_in[6:0])
      ADDR_SRC_SHIFT: rd_mux = {s_r.scale, s_r.src};
      ADDR_THR: rd_mux = {s_r.over, s_r.gain, s_r.rect, 2'b00, s_r.thr};
      ADDR_DEBOUNCE: rd_mux = {s_r.hook_db, s_r.pin_db};
      // Monitors answer only in port mode
      ADDR_MON_LO: rd_mux = mpi_mode_in ? s_r.mon_lo : 8'h00;
      ADDR_MON_HI: rd_mux = (mpi_mode_in && linear_coding_in) ? s_r.mon_hi : 8'h00;
      ADDR_RT: rd_mux = s_r.rt;
      ADDR_RBK: rd_mux = s_r.rbk;
      ADDR_ET: rd_mux = s_r.et;
      ADDR_EBRK: rd_mux = s_r.ebrk;
      ADDR_MASK: rd_mux = {3'b000, s_r.mask};
      default: rd_mux = 8'h00;
    endcase
    // Command byte handling
    case (s_r.st)
      ST_IDLE: begin
        if (byte_valid_in) begin
          if (byte_in[CMD_WRITE_BIT]) begin
            // Write: wait for the data byte
            s_nxt.addr = byte_in[6:0];
            s_nxt.st = ST_DATA;
          end else begin
            // Read: answer on the next cycle
            s_nxt.rdata = rd_mux;
            s_nxt.rvalid = 1'b1;
          end
        end
      end
      ST_DATA: begin
        if (byte_valid_in) begin
          s_nxt.st = ST_IDLE;
          case (s_r.addr)
            ADDR_SRC_SHIFT: begin
              s_nxt.scale = byte_in[7:SCALE_LSB];
              s_nxt.src = byte_in[3:0];
            end
            ADDR_THR: begin
              // Flag and reserved bits keep their value
              s_nxt.gain = byte_in[GAIN_BIT];
              s_nxt.rect = byte_in[RECT_BIT];
              s_nxt.thr = byte_in[2:0];
            end
            ADDR_DEBOUNCE: begin
              s_nxt.hook_db = byte_in[7:HOOK_DB_LSB];
              s_nxt.pin_db = byte_in[3:0];
            end
            ADDR_RT: s_nxt.rt = byte_in;
            ADDR_RBK: s_nxt.rbk = byte_in;
            ADDR_ET: s_nxt.et = byte_in;
            ADDR_EBRK: s_nxt.ebrk = byte_in;
            ADDR_MASK: s_nxt.mask = byte_in[4:0];
            // Read-only and unmapped: ignored
            default: s_nxt.mask = s_r.mask;
          endcase
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    // Meter update and threshold compare
    if (meter_valid_in) begin
      s_nxt.meter = m_out;
      s_nxt.over = m_abs > thr_level;
    end
    // Transmit sample capture
    if (tx_sample_valid_in) begin
      s_nxt.mon_lo = tx_sample_in[7:0];
      s_nxt.mon_hi = linear_coding_in ? tx_sample_in[15:8] : 8'h00;
    end
    // Hook interval tick: base 0.125 ms, every code+1 bases
    if (s_r.hdiv == 12'(HOOK_TICK_CYCLES - 1)) begin
      s_nxt.hdiv = 12'h000;
      if (s_r.hint == s_r.hook_db) begin
        s_nxt.hint = 4'h0;
        s_nxt.htick = 1'b1;
      end else begin
        s_nxt.hint = 4'(s_r.hint + 4'h1);
      end
    end else begin
      s_nxt.hdiv = 12'(s_r.hdiv + 12'h001);
    end
    // Pin tick every 0.5 ms
    if (s_r.pdiv == 16'(PIN_TICK_CYCLES - 1)) begin
      s_nxt.pdiv = 16'h0000;
      s_nxt.ptick = 1'b1;
    end else begin
      s_nxt.pdiv = 16'(s_r.pdiv + 16'h0001);
    end
    // Event detection against previous status
    s_nxt.gk_prev = ground_key_status_in;
    s_nxt.hk_prev = off_hook_status_in;
    s_nxt.ot_prev = overheat_status_in;
    s_nxt.ramp_prev = ramp_done_in;
    s_nxt.pol_prev = key_polarity_status_in;
    s_nxt.ev[MB_GK] = (|(ground_key_status_in ^ s_r.gk_prev)) & ~s_r.mask[MB_GK];
    s_nxt.ev[MB_HK] = (|(off_hook_status_in ^ s_r.hk_prev)) & ~s_r.mask[MB_HK];
    s_nxt.ev[MB_OT] = overheat_status_in & ~s_r.ot_prev & ~s_r.mask[MB_OT];
    s_nxt.ev[MB_RAMP] = ramp_done_in & ~s_r.ramp_prev & ~s_r.mask[MB_RAMP];
    s_nxt.ev[MB_POL] = (key_polarity_status_in ^ s_r.pol_prev) & ~s_r.mask[MB_POL];
  end

  // State register with documented defaults
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.rt <= RT_RST;
      s_r.rbk <= RBK_RST;
      s_r.et <= ET_RST;
      s_r.ebrk <= EBRK_RST;
      s_r.mask <= MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Hook and ground-key filters, sixteen intervals each
  debounce_filter u_hook_db (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .tick_in(s_r.htick),
    .need_in(HOOK_INTERVALS),
    .raw_in(hook_raw_in),
    .level_out(hook_level_out)
  );
  debounce_filter u_gk_db (
    .clock_in(clock_in),
    .rstn_in(rstn_in),
    .tick_in(s_r.htick),
    .need_in(HOOK_INTERVALS),
    .raw_in(ground_key_raw_in),
    .level_out(ground_key_level_out)
  );

  // Pin filters: 5 + 4*code half-ms ticks
  assign pin_need = 8'(PIN_BASE_TICKS + PIN_STEP_TICKS * 8'(s_r.pin_db));
  for (genvar i = 0; i < 4; i++) begin : g_pin
    debounce_filter u_pin_db (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .tick_in(s_r.ptick),
      .need_in(pin_need),
      .raw_in(pin_raw_in[i]),
      .level_out(pin_db_level[i])
    );
    // Output pins bypass the filter
    assign pin_level_out[i] = pin_is_input_in[i] ? pin_db_level[i] : pin_raw_in[i];
  end

  // Source code validity
  always_comb begin
    case (s_r.src)
      SRC_TIP_DC, SRC_DC_DIFF, SRC_LINE, SRC_PIN3, SRC_PIN4, SRC_RING_TRIP,
      SRC_HALF_SUPPLY, SRC_ENC_OFFSET, SRC_PIN_DIFF: meter_source_valid_out = 1'b1;
      default: meter_source_valid_out = 1'b0;
    endcase
  end

  // Outputs
  assign read_data_out = s_r.rdata;
  assign read_valid_out = s_r.rvalid;
  assign meter_result_out = s_r.meter;
  assign over_threshold_flag_out = s_r.over;
  assign meter_source_select_out = s_r.src;
  assign recognition_time_ms_out = {s_r.rt, 4'h0} >> (4 - RT_UNIT_SHIFT);
  assign recognition_break_ms_out = {s_r.rbk, 2'b00} >> (2 - BRK_UNIT_SHIFT);
  assign end_detect_ms_out = {s_r.et, 2'b00} >> (2 - BRK_UNIT_SHIFT);
  assign end_detect_break_ms_out = s_r.ebrk;
  assign event_out = s_r.ev;

  // Checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  sequence s_mask_cmd;
    s_r.st == ST_IDLE && byte_valid_in && byte_in == {1'b1, ADDR_MASK};
  endsequence
  sequence s_read_cmd;
    s_r.st == ST_IDLE && byte_valid_in && !byte_in[CMD_WRITE_BIT];
  endsequence

  property p_write_mask;
    s_mask_cmd ##1 byte_valid_in |=> s_r.mask == $past(byte_in[4:0]);
  endproperty
  a_write_mask: assert property (p_write_mask)
    else $error("mask write not stored");

  property p_read_answer;
    s_read_cmd |=> read_valid_out ##1 !read_valid_out;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer not a single pulse");

  property p_flag_ro;
    s_r.st == ST_DATA && byte_valid_in && s_r.addr == ADDR_THR && !meter_valid_in
      |=> $stable(over_threshold_flag_out);
  endproperty
  a_flag_ro: assert property (p_flag_ro)
    else $error("threshold write altered the flag");

  property p_hi_zero;
    s_read_cmd and (byte_in[6:0] == ADDR_MON_HI && !linear_coding_in)
      |=> read_data_out == 8'h00;
  endproperty
  a_hi_zero: assert property (p_hi_zero)
    else $error("high monitor nonzero in compressed mode");

  property p_flag_level;
    meter_valid_in && m_abs <= thr_level |=> !over_threshold_flag_out;
  endproperty
  a_flag_level: assert property (p_flag_level)
    else $error("flag set at or below threshold");

  property p_ot_rise;
    $rose(overheat_status_in) && !s_r.mask[MB_OT] && s_r.ot_prev == 1'b0
      |=> event_out[MB_OT] ##1 !event_out[MB_OT] || $rose(overheat_status_in);
  endproperty
  a_ot_rise: assert property (p_ot_rise)
    else $error("overheat rise missed");

  property p_ot_fall;
    $fell(overheat_status_in) |=> !event_out[MB_OT];
  endproperty
  a_ot_fall: assert property (p_ot_fall)
    else $error("overheat fall raised event");

  property p_ramp_rise;
    ramp_done_in && !s_r.ramp_prev && !s_r.mask[MB_RAMP] |=> event_out[MB_RAMP];
  endproperty
  a_ramp_rise: assert property (p_ramp_rise)
    else $error("ramp done missed");

  property p_pol_change;
    key_polarity_status_in != s_r.pol_prev && !s_r.mask[MB_POL] |=> event_out[MB_POL];
  endproperty
  a_pol_change: assert property (p_pol_change)
    else $error("polarity change missed");

  property p_hook_masked;
    s_r.mask[MB_HK] |=> !event_out[MB_HK];
  endproperty
  a_hook_masked: assert property (p_hook_masked)
    else $error("masked hook change raised event");

  property p_gk_change;
    ground_key_status_in != s_r.gk_prev && !s_r.mask[MB_GK] |=> event_out[MB_GK];
  endproperty
  a_gk_change: assert property (p_gk_change)
    else $error("ground key change missed");

  property p_reset_values;
    $rose(rstn_in) |-> s_r.mask == MASK_RST && s_r.rt == RT_RST && !over_threshold_flag_out;
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("wrong value after reset");
endmodule : channel_meter_tone_mask_regs

// [testbench/host_port_model.sv]
module host_port_model (
  input wire logic clock_in,
  input wire logic read_valid_in,
  input wire logic [7:0] read_data_in,
  output logic byte_valid_out,
  output logic [7:0] byte_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Port idle, no strobe
  initial begin
    byte_valid_out = 1'b0;
    byte_out = 8'h00;
  end
  // One byte held for one cycle from a falling edge
  task automatic put(input logic [7:0] b);
    @(negedge clock_in);
    byte_valid_out = 1'b1;
    byte_out = b;
  endtask : put
  // Release: strobe low, bus inverted so no stale byte is seen
  task automatic idle();
    @(negedge clock_in);
    byte_valid_out = 1'b0;
    byte_out = ~byte_out;
  endtask : idle
  // Write: top bit set, data after gap idle cycles
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int gap = 0);
    put({1'b1, a});
    repeat (gap) idle();
    put(d);
    idle();
  endtask : wr
  // Read: top bit clear, answer sampled in its one-cycle strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    put({1'b0, a});
    idle();
    ok = read_valid_in;
    d = read_data_in;
  endtask : rd
endmodule : host_port_model

// [testbench/channel_meter_tone_mask_regs_bench.sv]
module channel_meter_tone_mask_regs_bench;
  import channel_regs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PT = 20; // Short pin debounce tick
  logic clock_in, rstn_in, byte_valid_in, read_valid_out, mpi_mode_in, meter_valid_in;
  logic [7:0] byte_in, read_data_out, end_detect_break_ms_out;
  logic signed [15:0] meter_raw_in;
  logic signed [19:0] meter_result_out;
  logic over_threshold_flag_out, meter_source_valid_out, tx_sample_valid_in;
  logic linear_coding_in, hook_raw_in, ground_key_raw_in, hook_level_out;
  logic ground_key_level_out, overheat_status_in, ramp_done_in, key_polarity_status_in;
  logic [3:0] meter_source_select_out, pin_raw_in, pin_is_input_in, pin_level_out;
  logic [3:0] ground_key_status_in, off_hook_status_in;
  logic [15:0] tx_sample_in;
  logic [11:0] recognition_time_ms_out;
  logic [9:0] recognition_break_ms_out, end_detect_ms_out;
  logic [4:0] event_out;
  int n_fail = 0;
  int num_checks = 0;
  // Device under test
  channel_meter_tone_mask_regs #(.PIN_TICK_CYCLES(PT)) i_dut (
    .clock_in(clock_in), .rstn_in(rstn_in), .byte_valid_in(byte_valid_in),
    .byte_in(byte_in), .read_data_out(read_data_out), .read_valid_out(read_valid_out),
    .mpi_mode_in(mpi_mode_in), .meter_raw_in(meter_raw_in), .meter_valid_in(meter_valid_in),
    .meter_result_out(meter_result_out), .over_threshold_flag_out(over_threshold_flag_out),
    .meter_source_select_out(meter_source_select_out),
    .meter_source_valid_out(meter_source_valid_out), .tx_sample_in(tx_sample_in),
    .tx_sample_valid_in(tx_sample_valid_in), .linear_coding_in(linear_coding_in),
    .hook_raw_in(hook_raw_in), .ground_key_raw_in(ground_key_raw_in),
    .hook_level_out(hook_level_out), .ground_key_level_out(ground_key_level_out),
    .pin_raw_in(pin_raw_in), .pin_is_input_in(pin_is_input_in), .pin_level_out(pin_level_out),
    .recognition_time_ms_out(recognition_time_ms_out),
    .recognition_break_ms_out(recognition_break_ms_out), .end_detect_ms_out(end_detect_ms_out),
    .end_detect_break_ms_out(end_detect_break_ms_out),
    .ground_key_status_in(ground_key_status_in), .off_hook_status_in(off_hook_status_in),
    .overheat_status_in(overheat_status_in), .ramp_done_in(ramp_done_in),
    .key_polarity_status_in(key_polarity_status_in), .event_out(event_out));
  // Host on the command port
  host_port_model i_host (.clock_in(clock_in), .read_valid_in(read_valid_out),
    .read_data_in(read_data_out), .byte_valid_out(byte_valid_in), .byte_out(byte_in));
  // Clock, 50 ns period
  initial begin
    clock_in = 1'b0;
    forever #25 clock_in = ~clock_in;
  end
  // Value compare
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Register read and compare
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    i_host.rd(a, d, ok);
    chk({19'h0, ok}, 20'h1);
    chk({12'h0, d}, {12'h0, exp});
  endtask : rd_chk
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done
  // Reset values and an unmapped read
  task automatic t_reset();
    rd_chk(ADDR_SRC_SHIFT, 8'h00);
    rd_chk(ADDR_THR, 8'h00);
    rd_chk(ADDR_DEBOUNCE, 8'h00);
    rd_chk(ADDR_RT, 8'h13);
    rd_chk(ADDR_RBK, 8'h19);
    rd_chk(ADDR_ET, 8'h40);
    rd_chk(ADDR_EBRK, 8'h64);
    rd_chk(ADDR_MASK, 8'h1f);
    rd_chk(7'h30, 8'h00);
    chk(20'(recognition_time_ms_out), 20'd304);
    chk(20'(recognition_break_ms_out), 20'd100);
    chk(20'(end_detect_ms_out), 20'd256);
    chk(20'(end_detect_break_ms_out), 20'd100);
  endtask : t_reset
  // Full-range writes, reserved bits, slow data byte
  task automatic t_regs();
    i_host.wr(ADDR_THR, 8'hff, 2);
    rd_chk(ADDR_THR, 8'h67);
    i_host.wr(ADDR_RT, 8'hff);
    i_host.wr(ADDR_RBK, 8'hff, 1);
    i_host.wr(ADDR_ET, 8'hff);
    i_host.wr(ADDR_EBRK, 8'hff);
    i_host.wr(ADDR_MASK, 8'hff);
    rd_chk(ADDR_MASK, 8'h1f);
    chk(20'(recognition_time_ms_out), 20'd4080);
    chk(20'(recognition_break_ms_out), 20'd1020);
    chk(20'(end_detect_ms_out), 20'd1020);
    chk(20'(end_detect_break_ms_out), 20'd255);
  endtask : t_regs
  // Every source code, defined ones flagged
  task automatic t_source();
    for (int c = 0; c < 16; c++) begin
      i_host.wr(ADDR_SRC_SHIFT, 8'(c));
      chk(20'(meter_source_select_out), 20'(c));
      chk(20'(meter_source_valid_out), 20'(c == 0 || c == 4 || c >= 9));
      rd_chk(ADDR_SRC_SHIFT, 8'(c));
    end
  endtask : t_source
  // One meter sample with given settings
  task automatic meter(input logic [15:0] raw, input logic [3:0] sh, input logic g,
      input logic r, input logic [2:0] th, input logic [19:0] exp, input logic f);
    i_host.wr(ADDR_SRC_SHIFT, {sh, 4'h0});
    i_host.wr(ADDR_THR, {1'b0, g, r, 2'b00, th});
    meter_raw_in = raw;
    meter_valid_in = 1'b1;
    @(negedge clock_in);
    meter_valid_in = 1'b0;
    chk(meter_result_out, exp);
    chk(20'(over_threshold_flag_out), 20'(f));
  endtask : meter
  // Scaling, gain, rectifier, threshold edges
  task automatic t_meter();
    meter(16'h1001, 4'h0, 1'b0, 1'b0, 3'd1, 20'd4097, 1'b1);
    meter(16'h1000, 4'h0, 1'b0, 1'b0, 3'd1, 20'd4096, 1'b0);
    meter(16'h4000, 4'ha, 1'b0, 1'b0, 3'd0, 20'd16, 1'b1);
    meter(16'h4000, 4'hb, 1'b1, 1'b0, 3'd0, 20'd128, 1'b1);
    meter(16'h4000, 4'hf, 1'b1, 1'b0, 3'd0, 20'd128, 1'b1);
    meter(16'h0800, 4'h0, 1'b1, 1'b0, 3'd7, 20'd32768, 1'b1);
    meter(16'he000, 4'h1, 1'b0, 1'b0, 3'd1, -20'sd4096, 1'b0);
    meter(16'he000, 4'h1, 1'b0, 1'b1, 3'd0, 20'd4096, 1'b1);
    i_host.wr(ADDR_THR, 8'h00);
    rd_chk(ADDR_THR, 8'h80);
  endtask : t_meter
  // Transmit sample monitors by coding and port mode
  task automatic t_monitor();
    tx_sample_in = 16'ha55a;
    tx_sample_valid_in = 1'b1;
    @(negedge clock_in);
    tx_sample_valid_in = 1'b0;
    i_host.wr(ADDR_MON_LO, 8'hff);
    rd_chk(ADDR_MON_LO, 8'h5a);
    rd_chk(ADDR_MON_HI, 8'ha5);
    linear_coding_in = 1'b0;
    tx_sample_in = 16'h00c3;
    tx_sample_valid_in = 1'b1;
    @(negedge clock_in);
    tx_sample_valid_in = 1'b0;
    rd_chk(ADDR_MON_HI, 8'h00);
    rd_chk(ADDR_MON_LO, 8'hc3);
    mpi_mode_in = 1'b0;
    rd_chk(ADDR_MON_LO, 8'h00);
    mpi_mode_in = 1'b1;
  endtask : t_monitor
  // Status step: {ground key, off hook, overheat, ramp, polarity}
  task automatic ev(input logic [10:0] st, input logic [4:0] exp);
    logic [4:0] seen;
    int hits;
    seen = 5'h00;
    hits = 0;
    {ground_key_status_in, off_hook_status_in} = st[10:3];
    {overheat_status_in, ramp_done_in, key_polarity_status_in} = st[2:0];
    repeat (4) begin
      @(negedge clock_in);
      if (event_out !== 5'h00) begin
        hits++;
        seen = event_out;
      end
    end
    chk(20'(hits), 20'(exp != 5'h00));
    chk(20'(seen), 20'(exp));
  endtask : ev
  // Masked, then each event kind in both directions
  task automatic t_events();
    ev(11'h400, 5'h00);
    ev(11'h000, 5'h00);
    i_host.wr(ADDR_MASK, 8'h00);
    ev(11'h004, 5'h04);
    ev(11'h000, 5'h00);
    ev(11'h002, 5'h02);
    ev(11'h000, 5'h00);
    ev(11'h001, 5'h01);
    ev(11'h000, 5'h01);
    ev(11'h080, 5'h10);
    ev(11'h000, 5'h10);
    ev(11'h008, 5'h08);
    ev(11'h000, 5'h08);
    i_host.wr(ADDR_MASK, 8'h08);
    ev(11'h040, 5'h00);
    ev(11'h044, 5'h04);
  endtask : t_events
  // Pin and hook debounce timing bounds
  task automatic t_debounce();
    int n;
    // Short hook code only to bound the run; in service hosts use 0111 up
    i_host.wr(ADDR_DEBOUNCE, 8'h01);
    pin_is_input_in = 4'b0001;
    pin_raw_in = 4'b0011;
    hook_raw_in = 1'b1;
    ground_key_raw_in = 1'b1;
    @(negedge clock_in);
    chk(20'(pin_level_out), 20'h2);
    repeat (175) @(negedge clock_in);
    chk(20'(pin_level_out[0]), 20'h0);
    n = 0;
    while (pin_level_out[0] !== 1'b1 && n < 60) begin
      @(negedge clock_in);
      n++;
    end
    chk(20'(pin_level_out[0]), 20'h1);
    repeat (39700) @(negedge clock_in);
    chk(20'({hook_level_out, ground_key_level_out}), 20'h0);
    n = 0;
    while (hook_level_out !== 1'b1 && n < 3000) begin
      @(negedge clock_in);
      n++;
    end
    chk(20'({hook_level_out, ground_key_level_out}), 20'h3);
  endtask : t_debounce
  // Main sequence
  initial begin
    rstn_in = 1'b0;
    mpi_mode_in = 1'b1;
    linear_coding_in = 1'b1;
    meter_raw_in = 16'h0000;
    meter_valid_in = 1'b0;
    tx_sample_in = 16'h0000;
    tx_sample_valid_in = 1'b0;
    {hook_raw_in, ground_key_raw_in, pin_raw_in, pin_is_input_in} = 10'h000;
    {ground_key_status_in, off_hook_status_in} = 8'h00;
    {overheat_status_in, ramp_done_in, key_polarity_status_in} = 3'b000;
    repeat (4) @(negedge clock_in);
    rstn_in = 1'b1;
    t_reset();
    t_regs();
    t_source();
    t_meter();
    t_monitor();
    t_events();
    t_debounce();
    test_done();
  end
  // Watchdog
  initial begin
    repeat (100000) @(posedge clock_in);
    n_fail++;
    test_done();
  end
endmodule : channel_meter_tone_mask_regs_bench
